// file: common/bst_defines.svh
// Constants for the boundary-scan test port: opcodes, capture values and widths.
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH
`define BST_IR_W 10
`define BST_ID_W 32
`define BST_IR_CAPTURE 10'h155
`define BST_OP_EXTEST 10'h00F
`define BST_OP_SAMPLE 10'h005
`define BST_OP_BYPASS 10'h3FF
`define BST_OP_IDCODE 10'h006
`define BST_OP_USERCODE 10'h007
`define BST_OP_CLAMP 10'h00A
`define BST_OP_HIGHZ 10'h00B
`define BST_OP_CONFIG_IO 10'h00D
`define BST_OP_PULSE_CONFIG 10'h001
`define BST_IDCODE_DEFAULT 32'h0A5A_5001
`define BST_USERCODE_DEFAULT 32'hFFFF_FFFF
`define BST_CELL_RESET 1'h1
`endif

// file: common/bst_pkg.sv
// Types shared by the boundary-scan test port and its cell chain.
package bst_pkg;
   typedef enum logic [15:0] {
      TAP_RESET      = 16'h0001,
      TAP_IDLE       = 16'h0002,
      TAP_SEL_DR     = 16'h0004,
      TAP_CAPTURE_DR = 16'h0008,
      TAP_SHIFT_DR   = 16'h0010,
      TAP_EXIT1_DR   = 16'h0020,
      TAP_PAUSE_DR   = 16'h0040,
      TAP_EXIT2_DR   = 16'h0080,
      TAP_UPDATE_DR  = 16'h0100,
      TAP_SEL_IR     = 16'h0200,
      TAP_CAPTURE_IR = 16'h0400,
      TAP_SHIFT_IR   = 16'h0800,
      TAP_EXIT1_IR   = 16'h1000,
      TAP_PAUSE_IR   = 16'h2000,
      TAP_EXIT2_IR   = 16'h4000,
      TAP_UPDATE_IR  = 16'h8000
   } bst_tap_e;
   typedef enum logic [2:0] {
      BM_FUNC   = 3'h0,
      BM_SAMPLE = 3'h1,
      BM_EXTEST = 3'h2,
      BM_CLAMP  = 3'h3,
      BM_HIGHZ  = 3'h4
   } bst_mode_e;
   typedef enum logic [1:0] {
      DR_BYPASS = 2'h0,
      DR_ID     = 2'h1,
      DR_BSR    = 2'h2
   } bst_dr_e;
endpackage

// file: common/bst_cells_if.sv
// Connection between the test port controller and the boundary cell chain.
`timescale 1ns/1ps
interface bst_cells_if;
   logic capture;
   logic shift;
   logic update;
   logic tdi_bit;
   logic so;
   logic configured;
   bst_pkg::bst_mode_e mode;
   modport tap (output capture, output shift, output update, output tdi_bit, output configured,
                output mode, input so);
   modport cells (input capture, input shift, input update, input tdi_bit, input configured,
                  input mode, output so);
endinterface

// file: hdl/bst_cells.sv
// Boundary cell chain: per pin an input, an output-data and an output-enable cell with update latches.
`timescale 1ns/1ps
`include "bst_defines.svh"
module bst_cells #(
   parameter int NPINS = 8,
   parameter logic [NPINS-1:0] DIFF_MASK = '0
) (
   input wire logic core_clk,
   input wire logic nrst,
   bst_cells_if.cells bus,
   input wire logic [NPINS-1:0] pin_in,
   input wire logic [NPINS-1:0] core_out,
   input wire logic [NPINS-1:0] core_oe,
   output logic [NPINS-1:0] pin_out,
   output logic [NPINS-1:0] pin_oe
);
   import bst_pkg::*;
   localparam int CHAIN = 3 * NPINS;
   logic [NPINS-1:0] pin_s1_q, pin_s2_q;
   logic [CHAIN-1:0] cap, sr_q, sr_d, upd_q, upd_d;
   logic [NPINS-1:0] out_d, oe_d;
   logic test_drive, test_float;

   assign test_drive = (bus.mode == BM_EXTEST) || (bus.mode == BM_CLAMP);
   assign test_float = (bus.mode == BM_HIGHZ);
   assign bus.so = sr_q[0];

   genvar i;
   generate
      for (i = 0; i < NPINS; i++) begin : g_pin
         logic internal;
         // Differential pins act as internal cells once configured.
         assign internal = DIFF_MASK[i] & bus.configured;
         assign cap[3*i] = pin_s2_q[i];
         assign cap[3*i+1] = core_out[i];
         assign cap[3*i+2] = ~core_oe[i];
         // Enable cell at 0 drives the data cell.
         assign out_d[i] = (test_drive && !internal) ? upd_q[3*i+1] : core_out[i];
         assign oe_d[i] = internal ? core_oe[i] :
                          test_drive ? ~upd_q[3*i+2] :
                          test_float ? 1'b0 : core_oe[i];
      end
   endgenerate

   always_comb begin
      sr_d = sr_q;
      upd_d = upd_q;
      if (bus.capture) begin
         sr_d = cap;
      end else if (bus.shift) begin
         sr_d = {bus.tdi_bit, sr_q[CHAIN-1:1]};
      end
      if (bus.update) begin
         upd_d = sr_q;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         sr_q <= '0;
         upd_q <= {CHAIN{`BST_CELL_RESET}};
         pin_out <= '0;
         pin_oe <= '0;
      end else begin
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
         sr_q <= sr_d;
         upd_q <= upd_d;
         pin_out <= out_d;
         pin_oe <= oe_d;
      end
   end
endmodule

// file: hdl/bst_tap.sv
// Boundary-scan test port: controller, instruction decode, data registers and configuration control.
`timescale 1ns/1ps
`include "bst_defines.svh"
module bst_tap #(
   parameter int NPINS = 8,
   parameter logic [NPINS-1:0] DIFF_MASK = '0,
   // Identification value is arbitrary.
   parameter logic [31:0] ID_CODE = `BST_IDCODE_DEFAULT
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   input wire logic config_request_n,
   input wire logic config_busy,
   input wire logic configured,
   input wire logic [31:0] usercode,
   input wire logic [NPINS-1:0] pin_in,
   input wire logic [NPINS-1:0] core_out,
   input wire logic [NPINS-1:0] core_oe,
   output logic [NPINS-1:0] pin_out,
   output logic [NPINS-1:0] pin_oe,
   output bst_pkg::bst_mode_e test_mode,
   output logic config_abort,
   output logic config_restart
);
   import bst_pkg::*;

   logic [3:0] sync1_q, sync2_q;
   logic tck_prev_q;
   logic tck_s, tms_s, tdi_s, cfg_req_n_s, tck_rise, tck_fall;
   bst_tap_e state_q, state_d;
   logic [`BST_IR_W-1:0] ir_sr_q, ir_sr_d, ir_q, ir_d, op;
   bst_mode_e mode_q, mode_d;
   bst_dr_e dr_q, dr_d;
   logic byp_q, byp_d;
   logic [`BST_ID_W-1:0] id_q, id_d;
   logic intr_q, intr_d, restart_q, restart_d, tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
   logic allowed;
   bst_cells_if cif ();

   // Pins from the tester pass two flip-flops before use.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 4'h8;
         sync2_q <= 4'h8;
         tck_prev_q <= 1'b0;
      end else begin
         sync1_q <= {config_request_n, tdi, tms, tck};
         sync2_q <= sync1_q;
         tck_prev_q <= sync2_q[0];
      end
   end

   assign tck_s = sync2_q[0];
   assign tms_s = sync2_q[1];
   assign tdi_s = sync2_q[2];
   assign cfg_req_n_s = sync2_q[3];
   assign tck_rise = tck_s & ~tck_prev_q;
   assign tck_fall = ~tck_s & tck_prev_q;

   // Gate instructions while configuration runs uninterrupted.
   always_comb begin
      allowed = !config_busy || intr_q ||
                (ir_sr_q == `BST_OP_BYPASS) || (ir_sr_q == `BST_OP_IDCODE) ||
                (ir_sr_q == `BST_OP_SAMPLE) || (ir_sr_q == `BST_OP_CONFIG_IO);
      op = allowed ? ir_sr_q : `BST_OP_BYPASS;
   end

   // Standard controller transitions on the mode-select bit.
   always_comb begin
      unique case (state_q)
         TAP_RESET: state_d = tms_s ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: state_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: state_d = tms_s ? TAP_SEL_IR : TAP_CAPTURE_DR;
         TAP_CAPTURE_DR: state_d = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: state_d = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: state_d = tms_s ? TAP_UPDATE_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: state_d = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: state_d = tms_s ? TAP_UPDATE_DR : TAP_SHIFT_DR;
         TAP_UPDATE_DR: state_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: state_d = tms_s ? TAP_RESET : TAP_CAPTURE_IR;
         TAP_CAPTURE_IR: state_d = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: state_d = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: state_d = tms_s ? TAP_UPDATE_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: state_d = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: state_d = tms_s ? TAP_UPDATE_IR : TAP_SHIFT_IR;
         TAP_UPDATE_IR: state_d = tms_s ? TAP_SEL_DR : TAP_IDLE;
         default: state_d = TAP_RESET;
      endcase
      if (!tck_rise) begin
         state_d = state_q;
      end
   end

   always_comb begin
      ir_sr_d = ir_sr_q;
      ir_d = ir_q;
      mode_d = mode_q;
      dr_d = dr_q;
      byp_d = byp_q;
      id_d = id_q;
      intr_d = intr_q;
      restart_d = 1'b0;
      tdo_d = tdo_q;
      tdo_oe_d = tdo_oe_q;
      // Pulsing the request pin low ends the interrupt.
      if (!cfg_req_n_s) begin
         intr_d = 1'b0;
      end
      if (tck_rise) begin
         unique case (state_q)
            TAP_RESET: begin
               ir_d = `BST_OP_IDCODE;
               mode_d = BM_FUNC;
               dr_d = DR_ID;
            end
            // Load the alternating pattern for Shift-IR.
            TAP_CAPTURE_IR: ir_sr_d = `BST_IR_CAPTURE;
            TAP_SHIFT_IR: ir_sr_d = {tdi_s, ir_sr_q[`BST_IR_W-1:1]};
            TAP_UPDATE_IR: begin
               ir_d = op;
               mode_d = BM_FUNC;
               dr_d = DR_BYPASS;
               unique case (op)
                  `BST_OP_EXTEST: begin
                     mode_d = BM_EXTEST;
                     dr_d = DR_BSR;
                  end
                  `BST_OP_SAMPLE: begin
                     mode_d = BM_SAMPLE;
                     dr_d = DR_BSR;
                  end
                  `BST_OP_IDCODE: dr_d = DR_ID;
                  `BST_OP_USERCODE: dr_d = DR_ID;
                  `BST_OP_CLAMP: mode_d = BM_CLAMP;
                  `BST_OP_HIGHZ: mode_d = BM_HIGHZ;
                  // Abort configuration so testing may proceed.
                  `BST_OP_CONFIG_IO: intr_d = 1'b1;
                  `BST_OP_PULSE_CONFIG: begin
                     intr_d = 1'b0;
                     restart_d = 1'b1;
                  end
                  default: ir_d = `BST_OP_BYPASS;
               endcase
            end
            TAP_CAPTURE_DR: begin
               byp_d = 1'b0;
               // Load identification or user code for shifting.
               if (ir_q == `BST_OP_USERCODE) begin
                  id_d = configured ? usercode : `BST_USERCODE_DEFAULT;
               end else begin
                  id_d = ID_CODE;
               end
            end
            TAP_SHIFT_DR: begin
               byp_d = tdi_s;
               if (dr_q == DR_ID) begin
                  id_d = {tdi_s, id_q[`BST_ID_W-1:1]};
               end
            end
            default: begin
            end
         endcase
      end
      // Output moves on the falling edge, floats outside shifts.
      if (tck_fall) begin
         tdo_oe_d = (state_q == TAP_SHIFT_IR) || (state_q == TAP_SHIFT_DR);
         if (state_q == TAP_SHIFT_IR) begin
            tdo_d = ir_sr_q[0];
         end else if (dr_q == DR_ID) begin
            tdo_d = id_q[0];
         end else if (dr_q == DR_BSR) begin
            tdo_d = cif.so;
         end else begin
            tdo_d = byp_q;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= TAP_RESET;
         ir_sr_q <= '0;
         ir_q <= `BST_OP_IDCODE;
         mode_q <= BM_FUNC;
         dr_q <= DR_ID;
         byp_q <= 1'b0;
         id_q <= '0;
         intr_q <= 1'b0;
         restart_q <= 1'b0;
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ir_sr_q <= ir_sr_d;
         ir_q <= ir_d;
         mode_q <= mode_d;
         dr_q <= dr_d;
         byp_q <= byp_d;
         id_q <= id_d;
         intr_q <= intr_d;
         restart_q <= restart_d;
         tdo_q <= tdo_d;
         tdo_oe_q <= tdo_oe_d;
      end
   end

   assign cif.capture = tck_rise && (state_q == TAP_CAPTURE_DR) && (dr_q == DR_BSR);
   assign cif.shift = tck_rise && (state_q == TAP_SHIFT_DR) && (dr_q == DR_BSR);
   assign cif.update = tck_rise && (state_q == TAP_UPDATE_DR) && (dr_q == DR_BSR);
   assign cif.tdi_bit = tdi_s;
   assign cif.mode = mode_q;
   assign cif.configured = configured;

   bst_cells #(.NPINS(NPINS), .DIFF_MASK(DIFF_MASK)) u_cells (
      .core_clk(core_clk),
      .nrst(nrst),
      .bus(cif.cells),
      .pin_in(pin_in),
      .core_out(core_out),
      .core_oe(core_oe),
      .pin_out(pin_out),
      .pin_oe(pin_oe)
   );

   assign tdo = tdo_q;
   assign tdo_oe = tdo_oe_q;
   assign test_mode = mode_q;
   assign config_abort = intr_q;
   assign config_restart = restart_q;
endmodule

// file: sim/bst_tap_props.sv
// Concurrent checks on the pins of the boundary-scan test port.
`timescale 1ns/1ps
module bst_tap_props #(
   parameter int NPINS = 8,
   parameter logic [NPINS-1:0] DIFF_MASK = '0
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic tck,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic config_request_n,
   input wire logic config_busy,
   input wire logic configured,
   input wire logic [NPINS-1:0] core_out,
   input wire logic [NPINS-1:0] core_oe,
   input wire logic [NPINS-1:0] pin_out,
   input wire logic [NPINS-1:0] pin_oe,
   input wire bst_pkg::bst_mode_e test_mode,
   input wire logic config_abort,
   input wire logic config_restart
);
   import bst_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   tdo_fall_edge_a: assert property (($changed(tdo) || $changed(tdo_oe)) |-> $past(tck, 3) == 1'h0)
      else $error("serial output moved away from a falling test clock");
   reset_idle_a: assert property ($rose(nrst) |-> test_mode == BM_FUNC && !config_abort && !tdo_oe)
      else $error("port not idle after reset");
   restart_pulse_a: assert property (config_restart |=> !config_restart)
      else $error("reconfigure pulse longer than one cycle");
   restart_gate_a: assert property (config_restart && config_busy |->
      $past(config_abort) || $past(config_abort, 2) || $past(config_abort, 3))
      else $error("reconfigure issued during uninterrupted configuration");
   // An interrupt set in the cycle the request pin clears it may stand for one cycle only.
   abort_clear_pin_a: assert property ((!config_request_n) [*4] |-> !config_abort || !$past(config_abort))
      else $error("request pin low did not clear the interrupt");
   // Configured differential pins stay with the core, so they are left out here.
   highz_pins_a: assert property ((test_mode == BM_HIGHZ) [*2] |->
      (pin_oe & ~({NPINS{$past(configured)}} & DIFF_MASK)) == '0)
      else $error("pin driven in high impedance mode");
   func_pins_a: assert property ($past(test_mode) == BM_FUNC && $past(nrst, 2) |->
      pin_oe == $past(core_oe) && pin_out == $past(core_out))
      else $error("pins do not follow the core in functional mode");
   diff_pins_a: assert property (configured && $past(configured) && $past(nrst, 2) |->
      ((pin_oe ^ $past(core_oe)) & DIFF_MASK) == '0)
      else $error("configured differential pin taken by the scan cells");
   busy_refuse_a: assert property (config_busy && $past(config_busy) && !$past(config_abort) &&
      $changed(test_mode) |-> test_mode inside {BM_FUNC, BM_SAMPLE})
      else $error("test mode accepted during configuration");
endmodule
bind bst_tap bst_tap_props #(.NPINS(NPINS), .DIFF_MASK(DIFF_MASK)) bst_tap_props_inst (.core_clk, .nrst, .tck,
   .tdo, .tdo_oe, .config_request_n, .config_busy, .configured, .core_out, .core_oe, .pin_out, .pin_oe,
   .test_mode, .config_abort, .config_restart);

// file: sim/bst_tester.sv
// Boundary-scan tester model driving the test clock, mode select and serial data.
`timescale 1ns/1ps
module bst_tester (
   input wire logic core_clk,
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
   end
   // One test clock: fall with new mode and data, rise, then read the output.
   task automatic clk(input logic m, input logic d, output logic o);
      tck <= 1'h0;
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge core_clk);
      tck <= 1'h1;
      repeat (4) @(posedge core_clk);
      o = tdo;
   endtask
   task automatic tap_reset();
      logic o;
      for (int i = 0; i < 6; i++) begin
         clk(1'(i < 5), 1'h0, o);
      end
   endtask
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic o;
      dout = '0;
      if (ir) clk(1'h1, 1'h0, o);
      clk(1'h1, 1'h0, o);
      clk(1'h0, 1'h0, o);
      clk(1'h0, 1'h0, o);
      for (int i = 0; i < n; i++) begin
         clk(1'(i == n - 1), din[i], o);
         dout[i] = o;
      end
      clk(1'h1, 1'h0, o);
      clk(1'h0, 1'h0, o);
   endtask
endmodule

// file: sim/bst_tap_tb.sv
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/1ps
`include "bst_defines.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module bst_tap_tb;
   import bst_pkg::*;
   localparam logic [7:0] DMASK = 8'h03;
   // Identification value is arbitrary.
   localparam logic [31:0] ID = 32'h1234_5678;
   logic core_clk = 1'h0;
   logic nrst = 1'h0;
   logic tck, tms, tdi, tdo, tdo_oe, config_abort, config_restart;
   // request held low while testing unconfigured
   logic config_request_n = 1'h0;
   logic config_busy = 1'h0;
   logic configured = 1'h0;
   logic [31:0] usercode = 32'hC0DE_0042;
   logic [7:0] pin_in = 8'h96, core_out = 8'h3C, core_oe = 8'hC3, pin_out, pin_oe;
   bst_mode_e test_mode;
   logic [31:0] so;
   // A floating serial output shows the inverse, so a missing enable corrupts the data read.
   logic tdo_line;
   assign tdo_line = tdo_oe ? tdo : ~tdo;
   int error_cnt = 0;
   int n_tests = 0;
   int restarts = 0;
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) if (config_restart === 1'h1) restarts++;
   bst_tap #(.NPINS(8), .DIFF_MASK(DMASK), .ID_CODE(ID)) bst_tap_inst (.core_clk(core_clk), .nrst(nrst),
      .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .config_request_n(config_request_n),
      .config_busy(config_busy), .configured(configured), .usercode(usercode), .pin_in(pin_in),
      .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe), .test_mode(test_mode),
      .config_abort(config_abort), .config_restart(config_restart));
   bst_tester bst_tester_inst (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
   task automatic ir(input logic [9:0] op);
      bst_tester_inst.scan(1'h1, 10, {22'h0, op}, so);
      repeat (4) @(posedge core_clk);
   endtask
   function automatic logic [31:0] cells(input logic [7:0] i, input logic [7:0] d, input logic [7:0] e);
      cells = '0;
      for (int k = 0; k < 8; k++) begin
         cells[3*k+:3] = {e[k], d[k], i[k]};
      end
   endfunction
   task automatic pins(input bst_mode_e m, input logic [7:0] oe, input logic [7:0] o);
      `CHK("test_mode", m, test_mode)
      `CHK("pin_oe", oe, pin_oe)
      `CHK("pin_out", o, pin_out)
   endtask
   task automatic t_codes();
      bst_tester_inst.tap_reset();
      ir(`BST_OP_IDCODE);
      `CHK("ir_capture", 32'h155, so)
      `CHK("tdo_oe_idle", 1'h0, tdo_oe)
      bst_tester_inst.scan(1'h0, 32, 32'h0, so);
      `CHK("idcode", ID, so)
      ir(`BST_OP_USERCODE);
      bst_tester_inst.scan(1'h0, 32, 32'h0, so);
      `CHK("usercode", `BST_USERCODE_DEFAULT, so)
      ir(`BST_OP_BYPASS);
      bst_tester_inst.scan(1'h0, 3, 32'h5, so);
      `CHK("bypass", 32'h2, so)
   endtask
   task automatic t_pins(input logic [7:0] d, input logic [7:0] e, input logic [7:0] m);
      ir(`BST_OP_SAMPLE);
      pins(BM_SAMPLE, core_oe, core_out);
      bst_tester_inst.scan(1'h0, 24, cells(8'h0, d, e), so);
      `CHK("sample", cells(pin_in, 8'h0, ~core_oe), so & cells(8'hFF, 8'h0, 8'hFF))
      ir(`BST_OP_EXTEST);
      pins(BM_EXTEST, (~e & ~m) | (core_oe & m), (d & ~m) | (core_out & m));
      ir(`BST_OP_CLAMP);
      pins(BM_CLAMP, (~e & ~m) | (core_oe & m), (d & ~m) | (core_out & m));
      ir(`BST_OP_HIGHZ);
      `CHK("highz", 8'h0, pin_oe & ~m)
      ir(`BST_OP_BYPASS);
      pins(BM_FUNC, core_oe, core_out);
   endtask
   task automatic t_config();
      config_request_n <= 1'h1;
      config_busy <= 1'h1;
      // no clamp while configuration runs
      ir(`BST_OP_CLAMP);
      `CHK("refused", BM_FUNC, test_mode)
      ir(`BST_OP_CONFIG_IO);
      `CHK("abort", 1'h1, config_abort)
      ir(`BST_OP_EXTEST);
      `CHK("after_abort", BM_EXTEST, test_mode)
      ir(`BST_OP_PULSE_CONFIG);
      `CHK("abort_pulse", 1'h0, config_abort)
      `CHK("restarts", 1, restarts)
      ir(`BST_OP_CONFIG_IO);
      config_request_n <= 1'h0;
      repeat (8) @(posedge core_clk);
      `CHK("abort_pin", 1'h0, config_abort)
      config_request_n <= 1'h1;
      ir(`BST_OP_PULSE_CONFIG);
      `CHK("restart_refused", 1, restarts)
      config_busy <= 1'h0;
   endtask
   task automatic t_usercode_cfg();
      configured <= 1'h1;
      ir(`BST_OP_USERCODE);
      bst_tester_inst.scan(1'h0, 32, 32'h0, so);
      `CHK("usercode_cfg", 32'hC0DE_0042, so)
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      nrst <= 1'h1;
      repeat (2) @(posedge core_clk);
      t_codes();
      t_pins(8'hA5, 8'h0F, 8'h00);
      t_config();
      t_usercode_cfg();
      t_pins(8'h5A, 8'hF0, DMASK);
      summarize();
   end
   initial begin
      #500_000;
      error_cnt++;
      summarize();
   end
endmodule
